// ===== rtl/cpsgv_pkg.sv
// Constants and types for the codec pin-sense and general-purpose signal verb block
// Overview of operation
// R1 - Sense get answers presence in bit 31, impedance in bits 30:0.
// R2 - The sense execute verb starts an impedance measurement.
// R3 - Execute bit 0 picks tip or ring; ignored when ring sensing unsupported.
// R4 - Impedance reads all ones while invalid or measuring.
// R5 - Presence flag follows whether a plug sits in the jack.
// R6 - Pin unsolicited response waits until the measurement has completed.
// R7 - Amp control get/set: swap bit 2, amp power bit 1, balanced bit 0.
// R8 - On a non-pin node bits 1 and 0 are reserved.
// R9 - Swap bit exchanges left and right on input and output paths.
// R10 - Amp pin follows power bit, forced off while pin is in low power.
// R11 - One shared amp power value reached through any pin node.
// R12 - Balanced bit picks single-ended or balanced drive on doubled pins.
// R13 - Input data get returns pin states in bits 7:0; not writable.
// R14 - Sticky input bits clear on a data write and on reset.
// R15 - Wake-masked input change during link reset raises status change request.
// R16 - Wake, unsolicited and sticky masks reset to zero; missing pins read zero.
// R17 - Masked input change sends unsolicited response when group enables it.
// R18 - Sticky mask bit 1 latches on an edge, 0 follows the level.
// R19 - Output pins follow stored output data; get returns it.
// R20 - Bidirectional inputs read the sensed pin level and ignore writes.
// R21 - Bidirectional outputs store, drive and read back written values.
// R22 - Disabled output pins float yet read back the pending value.
// R23 - Direction bit 0 makes a pin an input, 1 an output.
// R24 - Enable bit 0 floats the pin; 1 hands it to direction control.
// R25 - Unsolicited control holds enable bit 7 and tag placed in bits 31:26.
// R26 - Output and bidirectional bits of missing pins read zero, ignore writes.
package cpsgv_pkg;
	localparam logic [11:0] VERB_UNSOL_GET = 12'hF08;
	localparam logic [11:0] VERB_UNSOL_SET = 12'h708;
	localparam logic [11:0] VERB_SENSE_GET = 12'hF09;
	localparam logic [11:0] VERB_SENSE_EXEC = 12'h709;
	localparam logic [11:0] VERB_AMP_GET = 12'hF0C;
	localparam logic [11:0] VERB_AMP_SET = 12'h70C;
	localparam logic [11:0] VERB_GPI_GET = 12'hF10;
	localparam logic [11:0] VERB_GPI_SET = 12'h710;
	localparam logic [11:0] VERB_WAKE_GET = 12'hF11;
	localparam logic [11:0] VERB_WAKE_SET = 12'h711;
	localparam logic [11:0] VERB_UMASK_GET = 12'hF12;
	localparam logic [11:0] VERB_UMASK_SET = 12'h712;
	localparam logic [11:0] VERB_STICKY_GET = 12'hF13;
	localparam logic [11:0] VERB_STICKY_SET = 12'h713;
	localparam logic [11:0] VERB_GPO_GET = 12'hF14;
	localparam logic [11:0] VERB_GPO_SET = 12'h714;
	localparam logic [11:0] VERB_GPIO_GET = 12'hF15;
	localparam logic [11:0] VERB_GPIO_SET = 12'h715;
	localparam logic [11:0] VERB_EN_GET = 12'hF16;
	localparam logic [11:0] VERB_EN_SET = 12'h716;
	localparam logic [11:0] VERB_DIR_GET = 12'hF17;
	localparam logic [11:0] VERB_DIR_SET = 12'h717;
	localparam int AMP_SWAP_BIT = 2;
	localparam int AMP_POWER_BIT = 1;
	localparam int AMP_BAL_BIT = 0;
	localparam int SENSE_RIGHT_BIT = 0;
	localparam int UNSOL_EN_BIT = 7;
	localparam int TAG_LSB = 26;
	localparam logic [30:0] IMP_INVALID = 31'h7FFFFFFF;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] GPI_IMPL = 8'h0F;
	localparam logic [7:0] GPO_IMPL = 8'h0F;
	localparam logic [7:0] GPIO_IMPL = 8'h0F;
	localparam logic RIGHT_SENSE_OK = 1'b1;
	localparam logic [1:0] POWER_FULL_ON = 2'h0;

	typedef struct packed {
		logic valid;
		logic pin_node;
		logic [11:0] id;
		logic [7:0] payload;
	} cpsgv_verb_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} cpsgv_resp_t;

	typedef enum logic [2:0] {
		MS_IDLE = 3'b001,
		MS_BUSY = 3'b010,
		MS_VALID = 3'b100
	} cpsgv_meas_t;
endpackage : cpsgv_pkg

// ===== rtl/cpsgv_top.sv
// Pin sense, amplifier control and general-purpose pin verbs of one codec node set
module cpsgv_top
	import cpsgv_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire cpsgv_verb_t VERB,
	output cpsgv_resp_t RESP,
	output cpsgv_resp_t UNSOL,
	output logic STATUS_CHANGE_REQ,
	input wire logic LINK_IN_RESET,
	input wire logic JACK_PRESENT,
	input wire logic [1:0] PIN_POWER_STATE,
	output logic IMP_START,
	output logic IMP_RIGHT,
	input wire logic IMP_DONE,
	input wire logic [30:0] IMP_VALUE,
	output logic EXT_AMP_POWER,
	output logic BALANCED_MODE,
	output logic CHAN_SWAP,
	input wire logic [7:0] GPI_IN,
	output logic [7:0] GPO_OUT,
	input wire logic [7:0] GPIO_IN,
	output logic [7:0] GPIO_OUT,
	output logic [7:0] GPIO_OE
);
	function automatic logic hit(input cpsgv_verb_t v, input logic [11:0] id);
		hit = v.valid && (v.id == id);
	endfunction : hit

	// Pin-side inputs pass two flip-flops before use
	logic [7:0] gpi_s1_reg, gpi_reg, gpio_s1_reg, gpio_in_reg;
	logic jack_s1_reg, jack_reg, link_s1_reg, link_rst_reg;
	always_ff @(posedge CLOCK) begin
		gpi_s1_reg <= GPI_IN;
		gpi_reg <= gpi_s1_reg;
		gpio_s1_reg <= GPIO_IN;
		gpio_in_reg <= gpio_s1_reg;
		jack_s1_reg <= JACK_PRESENT;
		jack_reg <= jack_s1_reg;
		link_s1_reg <= LINK_IN_RESET;
		link_rst_reg <= link_s1_reg;
	end

	logic [7:0] gpi_prev_reg;
	logic jack_prev_reg;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			gpi_prev_reg <= MASK_RESET;
			jack_prev_reg <= 1'b0;
		end else begin
			gpi_prev_reg <= gpi_reg;
			jack_prev_reg <= jack_reg;
		end
	end

	// Unsolicited controls: one for the function group, one for the pin node
	logic [7:0] fg_unsol_reg, pin_unsol_reg;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			fg_unsol_reg <= MASK_RESET;
			pin_unsol_reg <= MASK_RESET;
		end else if (hit(VERB, VERB_UNSOL_SET)) begin
			if (VERB.pin_node)
				pin_unsol_reg <= VERB.payload & 8'hBF; // R25
			else
				fg_unsol_reg <= VERB.payload & 8'hBF; // R25
		end
	end

	// Impedance measurement sequencing
	cpsgv_meas_t meas_reg;
	logic [30:0] imp_reg;
	logic meas_done_evt;
	assign meas_done_evt = (meas_reg == MS_BUSY) && IMP_DONE;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			meas_reg <= MS_IDLE;
			imp_reg <= IMP_INVALID;
		end else begin
			case (meas_reg)
				MS_IDLE, MS_VALID: begin
					if (hit(VERB, VERB_SENSE_EXEC)) begin
						meas_reg <= MS_BUSY; // R2
						imp_reg <= IMP_INVALID; // R4
					end
				end
				MS_BUSY: begin
					if (IMP_DONE) begin
						meas_reg <= MS_VALID;
						imp_reg <= IMP_VALUE;
					end
				end
				default: begin
					meas_reg <= MS_IDLE;
					imp_reg <= IMP_INVALID;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			IMP_START <= 1'b0;
			IMP_RIGHT <= 1'b0;
		end else begin
			IMP_START <= hit(VERB, VERB_SENSE_EXEC) && (meas_reg != MS_BUSY); // R2
			if (hit(VERB, VERB_SENSE_EXEC))
				IMP_RIGHT <= VERB.payload[SENSE_RIGHT_BIT] & RIGHT_SENSE_OK; // R3
		end
	end

	// Amplifier power, balanced drive and channel swap
	logic [2:0] amp_reg;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			amp_reg <= 3'h0;
		end else if (hit(VERB, VERB_AMP_SET)) begin
			amp_reg[AMP_SWAP_BIT] <= VERB.payload[AMP_SWAP_BIT]; // R7
			if (VERB.pin_node) begin
				amp_reg[AMP_POWER_BIT] <= VERB.payload[AMP_POWER_BIT]; // R11
				amp_reg[AMP_BAL_BIT] <= VERB.payload[AMP_BAL_BIT]; // R8
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			EXT_AMP_POWER <= 1'b0;
			BALANCED_MODE <= 1'b0;
			CHAN_SWAP <= 1'b0;
		end else begin
			EXT_AMP_POWER <= amp_reg[AMP_POWER_BIT] && (PIN_POWER_STATE == POWER_FULL_ON); // R10
			BALANCED_MODE <= amp_reg[AMP_BAL_BIT]; // R12
			CHAN_SWAP <= amp_reg[AMP_SWAP_BIT]; // R9
		end
	end

	// General input masks and sticky latches
	logic [7:0] wake_reg, umask_reg, sticky_reg, latch_reg, general_input_levels;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			wake_reg <= MASK_RESET; // R16
			umask_reg <= MASK_RESET; // R16
			sticky_reg <= MASK_RESET; // R16
		end else begin
			if (hit(VERB, VERB_WAKE_SET))
				wake_reg <= VERB.payload & GPI_IMPL; // R15
			if (hit(VERB, VERB_UMASK_SET))
				umask_reg <= VERB.payload & GPI_IMPL; // R17
			if (hit(VERB, VERB_STICKY_SET))
				sticky_reg <= VERB.payload & GPI_IMPL; // R18
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sticky
			logic rise;
			logic clr;
			assign rise = gpi_reg[gi] && !gpi_prev_reg[gi] && GPI_IMPL[gi];
			assign clr = hit(VERB, VERB_GPI_SET) && VERB.payload[gi];
			always_ff @(posedge CLOCK) begin
				if (RESET)
					latch_reg[gi] <= 1'b0; // R14
				else if (rise)
					latch_reg[gi] <= 1'b1; // R18
				else if (clr)
					latch_reg[gi] <= 1'b0; // R14
			end
			assign general_input_levels[gi] = GPI_IMPL[gi] && (sticky_reg[gi] ? latch_reg[gi] : gpi_reg[gi]); // R13
		end
	endgenerate

	// Input change events: wake while link is held, unsolicited while link is up
	logic [7:0] gpi_change;
	logic gpi_unsol_evt, wake_evt;
	assign gpi_change = (gpi_reg ^ gpi_prev_reg) & GPI_IMPL;
	assign wake_evt = link_rst_reg && |(gpi_change & wake_reg);
	assign gpi_unsol_evt = !link_rst_reg && fg_unsol_reg[UNSOL_EN_BIT] && |(gpi_change & umask_reg);
	always_ff @(posedge CLOCK) begin
		if (RESET)
			STATUS_CHANGE_REQ <= 1'b0;
		else
			STATUS_CHANGE_REQ <= wake_evt; // R15
	end

	// Pending unsolicited responses; hardware set beats the send clear
	logic gpi_pend_reg, pin_pend_reg, pin_evt, send_gpi, send_pin;
	assign pin_evt = pin_unsol_reg[UNSOL_EN_BIT] && ((jack_reg != jack_prev_reg) || meas_done_evt);
	assign send_gpi = gpi_pend_reg && !link_rst_reg;
	assign send_pin = pin_pend_reg && !send_gpi && (meas_reg != MS_BUSY) && !link_rst_reg; // R6
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			gpi_pend_reg <= 1'b0;
			pin_pend_reg <= 1'b0;
		end else begin
			if (gpi_unsol_evt)
				gpi_pend_reg <= 1'b1; // R17
			else if (send_gpi)
				gpi_pend_reg <= 1'b0;
			if (pin_evt)
				pin_pend_reg <= 1'b1;
			else if (send_pin)
				pin_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			UNSOL <= '0;
		end else begin
			UNSOL.valid <= send_gpi || send_pin;
			UNSOL.data <= '0;
			if (send_gpi)
				UNSOL.data[31:TAG_LSB] <= fg_unsol_reg[5:0]; // R25
			else if (send_pin)
				UNSOL.data[31:TAG_LSB] <= pin_unsol_reg[5:0]; // R25
		end
	end

	// Output and bidirectional pins
	logic [7:0] gpo_reg, gpio_reg, gpio_en_reg, gpio_dir_reg;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			gpo_reg <= MASK_RESET;
			gpio_reg <= MASK_RESET;
			gpio_en_reg <= MASK_RESET;
			gpio_dir_reg <= MASK_RESET;
		end else begin
			if (hit(VERB, VERB_GPO_SET))
				gpo_reg <= VERB.payload & GPO_IMPL; // R26
			if (hit(VERB, VERB_GPIO_SET))
				gpio_reg <= (VERB.payload & gpio_dir_reg & GPIO_IMPL) | (gpio_reg & ~gpio_dir_reg); // R21
			if (hit(VERB, VERB_EN_SET))
				gpio_en_reg <= VERB.payload & GPIO_IMPL; // R24
			if (hit(VERB, VERB_DIR_SET))
				gpio_dir_reg <= VERB.payload & GPIO_IMPL; // R23
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			GPO_OUT <= MASK_RESET;
			GPIO_OUT <= MASK_RESET;
			GPIO_OE <= MASK_RESET;
		end else begin
			GPO_OUT <= gpo_reg; // R19
			GPIO_OUT <= gpio_reg; // R21
			GPIO_OE <= gpio_en_reg & gpio_dir_reg; // R22
		end
	end

	// Response word for get verbs, one cycle after the verb
	logic [31:0] resp_next;
	always_comb begin
		resp_next = '0;
		case (VERB.id)
			VERB_SENSE_GET: resp_next = {jack_reg, (meas_reg == MS_VALID) ? imp_reg : IMP_INVALID}; // R1 R4 R5
			VERB_AMP_GET: resp_next = VERB.pin_node ? {29'h0, amp_reg} : {29'h0, amp_reg[AMP_SWAP_BIT], 2'h0}; // R8
			VERB_UNSOL_GET: resp_next = {24'h0, VERB.pin_node ? pin_unsol_reg : fg_unsol_reg};
			VERB_GPI_GET: resp_next = {24'h0, general_input_levels}; // R13
			VERB_WAKE_GET: resp_next = {24'h0, wake_reg};
			VERB_UMASK_GET: resp_next = {24'h0, umask_reg};
			VERB_STICKY_GET: resp_next = {24'h0, sticky_reg};
			VERB_GPO_GET: resp_next = {24'h0, gpo_reg}; // R19
			VERB_GPIO_GET: resp_next = {24'h0, ((gpio_reg & gpio_dir_reg) | (gpio_in_reg & ~gpio_dir_reg)) & GPIO_IMPL}; // R20
			VERB_EN_GET: resp_next = {24'h0, gpio_en_reg};
			VERB_DIR_GET: resp_next = {24'h0, gpio_dir_reg};
			default: resp_next = '0;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			RESP <= '0;
		end else begin
			RESP.valid <= VERB.valid;
			RESP.data <= VERB.valid ? resp_next : 32'h0;
		end
	end

	AST_AMP_LOWPOWER: assert property (@(posedge CLOCK) disable iff (RESET) // R10
		(PIN_POWER_STATE != POWER_FULL_ON) |=> !EXT_AMP_POWER)
		else $error("amp pin powered while pin widget in low power");
	AST_AMP_FOLLOW: assert property (@(posedge CLOCK) disable iff (RESET) // R11
		hit(VERB, VERB_AMP_SET) && VERB.pin_node && (PIN_POWER_STATE == POWER_FULL_ON) ##1
		(PIN_POWER_STATE == POWER_FULL_ON) |=> EXT_AMP_POWER == $past(VERB.payload[AMP_POWER_BIT], 2))
		else $error("amp pin does not follow written power bit");
	AST_NONPIN_RSVD: assert property (@(posedge CLOCK) disable iff (RESET) // R8
		hit(VERB, VERB_AMP_SET) && !VERB.pin_node |=> $stable(amp_reg[1:0]))
		else $error("non-pin node changed reserved amp bits");
	AST_SENSE_BUSY: assert property (@(posedge CLOCK) disable iff (RESET) // R4
		hit(VERB, VERB_SENSE_GET) && (meas_reg != MS_VALID) |=> RESP.data[30:0] == IMP_INVALID)
		else $error("impedance not all ones while busy or invalid");
	AST_EXEC_START: assert property (@(posedge CLOCK) disable iff (RESET) // R2
		hit(VERB, VERB_SENSE_EXEC) && (meas_reg != MS_BUSY) |=> IMP_START && (meas_reg == MS_BUSY))
		else $error("execute verb did not start a measurement");
	AST_PIN_UNSOL_WAIT: assert property (@(posedge CLOCK) disable iff (RESET) // R6
		(meas_reg == MS_BUSY) && !send_gpi |=> !UNSOL.valid)
		else $error("pin unsolicited response sent during measurement");
	AST_UNSOL_TAG: assert property (@(posedge CLOCK) disable iff (RESET) // R25
		send_gpi |=> UNSOL.valid && (UNSOL.data[31:TAG_LSB] == $past(fg_unsol_reg[5:0])))
		else $error("unsolicited response tag wrong");
	AST_WAKE: assert property (@(posedge CLOCK) disable iff (RESET) // R15
		wake_evt |=> STATUS_CHANGE_REQ ##1 !STATUS_CHANGE_REQ || $past(wake_evt, 1) || wake_evt)
		else $error("wake change did not raise status change request");
	AST_GPIO_OE: assert property (@(posedge CLOCK) disable iff (RESET) // R24
		!gpio_en_reg[0] |=> !GPIO_OE[0])
		else $error("disabled bidirectional pin driven");
	AST_GPO_READ: assert property (@(posedge CLOCK) disable iff (RESET) // R19
		hit(VERB, VERB_GPO_SET) ##1 hit(VERB, VERB_GPO_GET) |=> RESP.data[7:0] == ($past(VERB.payload, 2) & GPO_IMPL))
		else $error("output data readback mismatch");
endmodule : cpsgv_top

// ===== sim/cpsgv_host.sv
// Host controller model that issues verbs over the link and collects the answers
module cpsgv_host
	import cpsgv_pkg::*;
(
	input wire logic clock,
	output cpsgv_verb_t verb,
	input wire cpsgv_resp_t resp
);
	timeunit 1ns;
	timeprecision 1ps;

	initial verb = '0;

	// One verb per call; the answer is taken 1 ns after the edge at which the block samples the verb
	task automatic send(input logic pin, input logic [11:0] id, input logic [7:0] pl, output logic [31:0] data,
		output logic ok);
		@(posedge clock);
		verb <= '{valid: 1'b1, pin_node: pin, id: id, payload: pl};
		@(posedge clock);
		verb <= '0;
		#1;
		ok = resp.valid;
		data = resp.data;
	endtask : send
endmodule : cpsgv_host

// ===== sim/cpsgv_top_tb.sv
// Self-checking testbench for the pin sense and general-purpose signal verb block
module cpsgv_top_tb;
	import cpsgv_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0;
	logic reset = 1'b1;
	cpsgv_verb_t verb;
	cpsgv_resp_t resp, unsol;
	logic scr, imp_start, imp_right, amp, bal, swp, early;
	logic link_rst = 1'b0;
	logic jack = 1'b1;
	logic imp_done = 1'b0;
	logic [1:0] pwr = 2'h0;
	logic [30:0] imp_value = 31'h0;
	logic [7:0] general_input_pins = 8'h00;
	logic [7:0] gpio_in = 8'h00;
	logic [7:0] general_output_pins, gpio_out, gpio_oe, en, dir, wr, pin, r;
	logic [3:0] busy_cnt = 4'h0;
	logic [31:0] d;
	logic ok;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;

	always #2.5 clock = ~clock;

	cpsgv_host host (.clock(clock), .verb(verb), .resp(resp));

	cpsgv_top DUT (.CLOCK(clock), .RESET(reset), .VERB(verb), .RESP(resp), .UNSOL(unsol),
		.STATUS_CHANGE_REQ(scr), .LINK_IN_RESET(link_rst), .JACK_PRESENT(jack), .PIN_POWER_STATE(pwr),
		.IMP_START(imp_start), .IMP_RIGHT(imp_right), .IMP_DONE(imp_done), .IMP_VALUE(imp_value),
		.EXT_AMP_POWER(amp), .BALANCED_MODE(bal), .CHAN_SWAP(swp), .GPI_IN(general_input_pins), .GPO_OUT(general_output_pins),
		.GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe));

	// Measurement engine: finishes six cycles after a start, flags any unsolicited answer while busy
	always @(posedge clock) begin
		imp_done <= 1'b0;
		if (imp_start === 1'b1)
			busy_cnt <= 4'h6;
		else if (busy_cnt == 4'h1) begin
			imp_done <= 1'b1;
			busy_cnt <= 4'h0;
		end else if (busy_cnt != 4'h0)
			busy_cnt <= busy_cnt - 4'h1;
		if (busy_cnt != 4'h0 && unsol.valid === 1'b1)
			early <= 1'b1;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	function automatic logic [31:0] gpio_exp(input logic [7:0] dr, input logic [7:0] w, input logic [7:0] p);
		return {24'h0, ((dr & w) | (~dr & p)) & GPIO_IMPL};
	endfunction : gpio_exp

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic vx(input logic p, input logic [11:0] id, input logic [7:0] pl, input logic [31:0] exp);
		host.send(p, id, pl, d, ok);
		chk("response valid", {31'h0, ok}, 32'h1);
		chk("response data", d, exp);
	endtask : vx

	// Waits a bounded time for an unsolicited answer; also reports a status change request
	task automatic wait_ev(input int lim, output logic [31:0] data, output logic req);
		int n;
		data = 32'hFFFFFFFF;
		req = 1'b0;
		for (n = 0; n < lim; n++) begin
			@(posedge clock);
			#1;
			if (scr === 1'b1)
				req = 1'b1;
			if (unsol.valid === 1'b1) begin
				data = unsol.data;
				break;
			end
		end
	endtask : wait_ev

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	initial begin
		early = 1'b0;
		void'($urandom(32'h1818));
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		imp_value <= 31'($urandom);
		repeat (3) @(posedge clock);
		vx(1'b0, VERB_WAKE_GET, 8'h00, 32'h0);
		vx(1'b0, VERB_UMASK_GET, 8'h00, 32'h0);
		vx(1'b0, VERB_STICKY_GET, 8'h00, 32'h0);
		for (int i = 0; i < 6; i++) begin
			r = (i < 2) ? {8{i[0]}} : 8'($urandom);
			vx(1'b0, VERB_GPO_SET, r, 32'h0);
			vx(1'b0, VERB_GPO_GET, 8'h00, {24'h0, r & GPO_IMPL});
			chk("output pins", {24'h0, general_output_pins}, {24'h0, r & GPO_IMPL});
		end
		vx(1'b1, VERB_AMP_SET, 8'hFF, 32'h0);
		vx(1'b1, VERB_AMP_GET, 8'h00, 32'h7);
		chk("swap amp balanced", {29'h0, swp, amp, bal}, 32'h7);
		@(posedge clock) pwr <= 2'h2;
		repeat (3) @(posedge clock);
		chk("amp in low power", {31'h0, amp}, 32'h0);
		vx(1'b0, VERB_AMP_SET, 8'h00, 32'h0);
		vx(1'b1, VERB_AMP_GET, 8'h00, 32'h3);
		@(posedge clock) pwr <= 2'h0;
		repeat (3) @(posedge clock);
		chk("amp back on", {31'h0, amp}, 32'h1);
		r = 8'($urandom);
		@(posedge clock) general_input_pins <= r;
		repeat (4) @(posedge clock);
		vx(1'b0, VERB_GPI_SET, 8'hFF, 32'h0);
		vx(1'b0, VERB_GPI_GET, 8'h00, {24'h0, r & GPI_IMPL});
		@(posedge clock) general_input_pins <= 8'h00;
		vx(1'b0, VERB_STICKY_SET, 8'hF1, 32'h0);
		vx(1'b0, VERB_STICKY_GET, 8'h00, 32'h1);
		@(posedge clock) general_input_pins <= 8'h01;
		@(posedge clock) general_input_pins <= 8'h00;
		repeat (4) @(posedge clock);
		vx(1'b0, VERB_GPI_GET, 8'h00, 32'h1);
		vx(1'b0, VERB_GPI_SET, 8'h01, 32'h0);
		vx(1'b0, VERB_GPI_GET, 8'h00, 32'h0);
		vx(1'b0, VERB_STICKY_SET, 8'h00, 32'h0);
		vx(1'b0, VERB_UNSOL_SET, 8'hA5, 32'h0);
		vx(1'b0, VERB_UMASK_SET, 8'h02, 32'h0);
		@(posedge clock) general_input_pins <= 8'h02;
		wait_ev(10, d, ok);
		chk("input unsolicited", d, {6'h25, 26'h0});
		vx(1'b0, VERB_UMASK_SET, 8'h00, 32'h0);
		vx(1'b0, VERB_WAKE_SET, 8'h02, 32'h0);
		@(posedge clock) link_rst <= 1'b1;
		repeat (4) @(posedge clock);
		general_input_pins <= 8'h00;
		wait_ev(10, d, ok);
		chk("wake request", {31'h0, ok}, 32'h1);
		@(posedge clock) link_rst <= 1'b0;
		repeat (4) @(posedge clock);
		vx(1'b1, VERB_UNSOL_SET, 8'h8A, 32'h0);
		vx(1'b1, VERB_SENSE_GET, 8'h00, {1'b1, IMP_INVALID});
		vx(1'b1, VERB_SENSE_EXEC, 8'h01, 32'h0);
		chk("measure start ring", {30'h0, imp_start, imp_right}, 32'h3);
		vx(1'b1, VERB_SENSE_GET, 8'h00, {1'b1, IMP_INVALID});
		wait_ev(12, d, ok);
		chk("sense unsolicited", d, {6'h0A, 26'h0});
		chk("answer while busy", {31'h0, early}, 32'h0);
		vx(1'b1, VERB_SENSE_GET, 8'h00, {1'b1, imp_value});
		vx(1'b1, VERB_SENSE_EXEC, 8'h00, 32'h0);
		chk("measure tip", {31'h0, imp_right}, 32'h0);
		@(posedge clock) jack <= 1'b0;
		repeat (16) @(posedge clock);
		vx(1'b1, VERB_SENSE_GET, 8'h00, {1'b0, imp_value});
		for (int i = 0; i < 4; i++) begin
			en = (i == 0) ? 8'h03 : 8'($urandom);
			dir = (i == 0) ? 8'h05 : 8'($urandom);
			wr = 8'($urandom);
			pin = 8'($urandom);
			@(posedge clock) gpio_in <= pin;
			vx(1'b0, VERB_EN_SET, en, 32'h0);
			vx(1'b0, VERB_DIR_SET, dir, 32'h0);
			vx(1'b0, VERB_GPIO_SET, wr, 32'h0);
			vx(1'b0, VERB_GPIO_GET, 8'h00, gpio_exp(dir, wr, pin));
			chk("pin enables", {24'h0, gpio_oe}, {24'h0, en & dir & GPIO_IMPL});
			chk("driven pins", {24'h0, gpio_out & gpio_oe}, {24'h0, en & dir & wr & GPIO_IMPL});
		end
		wrap_up();
	end
endmodule : cpsgv_top_tb
